// File: hdl/link_status_monitor.sv
`timescale 1ns/1ps
//Contract
//[R1] checksum each long packet payload; mismatch sets checksum error status
//[R2] checksum error indication may be forwarded over the control channel
//[R3] five receiver status registers: count, status, lanes 01, 23, clock
//[R4] forward frames are 40 bits, balanced, carry video, i2c, crc, state
//[R5] back-channel frames are 30 bits carrying i2c and gpio content
//[R6] recover clock and data; bit rate is half highest frequency
//[R7] back-channel rate programmable, default from mode strap
//[R8] fast pll lock shows in link status bit 2
//[R9] remote receiver lock shows in link status bit 6
//[R10] back-channel crc error flagged in link status bit 1
//[R11] back-channel crc errors counted across two byte registers
//[R12] writing 1 to clear bit 3 zeroes back-channel counters
//[R13] self-test crc error flagged in link status bit 3
//[R14] self-test errors counted in self-test count register
//[R15] writing 1 to clear bit 5 zeroes self-test counter
//[R16] voltage and temperature sensors each give 3-bit codes
//[R17] codes compared with limits; alarm may go to deserializer
//[R18] either general pin zero or one selects the measured voltage
//[R19] voltage code steps by 50 mV from 0.85 to 1.15 V
//[R20] temperature code bands at -30,-10,15,35,55,75,100 C
//[R21] sensor status bits 2 and 3 show voltage below/above limits
//[R22] host configures enable, select, limits, alarms, forwarding
//[R23] counters saturate and hold; clear bits act once per write
module link_status_monitor (
	input  wire logic                  i_clock,
	input  wire logic                  i_sys_rst,
	input  wire logic                  i_scl,
	input  wire logic                  i_sda,
	output logic                       o_sda_out,
	output logic                       o_sda_oe,
	input  wire logic                  i_bc_line,
	input  wire logic                  i_mode_strap,
	input  wire logic                  i_fast_pll_locked,
	input  wire lsm_pkg::csi_pkt_s     i_pkt,
	input  wire lsm_pkg::lane_err_s    i_lane_err,
	input  wire logic [15:0]           i_video,
	input  wire logic [7:0]            i_fwd_i2c,
	input  wire logic [1:0][10:0]      i_pin_mv,
	input  wire logic signed [7:0]     i_temp_c,
	output logic [39:0]                o_fwd_frame,
	output logic                       o_fwd_strobe,
	output logic [7:0]                 o_bc_i2c,
	output logic [3:0]                 o_bc_gpio,
	output logic                       o_bc_strobe
);
	typedef enum logic [2:0] {
		st_idle, st_addr, st_reg, st_wdata, st_rdata, st_rack
	} i2c_st_e;

	function automatic logic [7:0] crc8_bit(input logic [7:0] c,
		input logic b);
		return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? lsm_pkg::CRC8_POLY : 8'h00);
	endfunction

	function automatic logic [7:0] crc8_word(input logic [29:0] w);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 29; i >= 0; i--)
			r = crc8_bit(r, w[i]);
		return r;
	endfunction

	function automatic logic [15:0] crc16_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ lsm_pkg::CRC16_POLY) : (r >> 1);
		return r;
	endfunction

	function automatic logic [2:0] volt_code(input logic [10:0] mv);
		if (int'(mv) < lsm_pkg::VOLT_MIN_MV)
			return 3'h0;
		if (int'(mv) >= lsm_pkg::VOLT_MAX_MV)
			return 3'h7;
		return 3'((int'(mv) - lsm_pkg::VOLT_MIN_MV)
			/ lsm_pkg::VOLT_STEP_MV + 1);
	endfunction

	function automatic logic [2:0] temp_code(input logic signed [7:0] t);
		int n;
		n = 0;
		for (int i = 0; i < 7; i++)
			if (int'(t) > lsm_pkg::TEMP_BOUND[i])
				n++;
		return 3'(n);
	endfunction

	// pin inputs: three flops, a change counts when stages two and three agree
	wire  logic [4:0] async_in = {i_mode_strap, i_fast_pll_locked,
		i_bc_line, i_sda, i_scl};
	logic [4:0] sync_q;
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_sync
			logic [2:0] s_q;
			always_ff @(posedge i_clock) begin
				if (i_sys_rst) begin
					s_q <= 3'h0;
					sync_q[g] <= 1'b0;
				end else begin
					s_q <= {s_q[1:0], async_in[g]};
					if (s_q[1] == s_q[2])
						sync_q[g] <= s_q[2];
				end
			end
		end
	endgenerate
	wire logic scl = sync_q[0];
	wire logic sda = sync_q[1];
	wire logic bcl = sync_q[2];
	wire logic pll_lock = sync_q[3];
	wire logic strap = sync_q[4];

	// i2c line events
	logic       scl_prev_q;
	logic       sda_prev_q;
	i2c_st_e    i2c_q;
	logic       ack_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic [7:0] rd_data;
	wire  logic scl_rise = scl & ~scl_prev_q;
	wire  logic scl_fall = ~scl & scl_prev_q;
	wire  logic i2c_start = scl & scl_prev_q & sda_prev_q & ~sda;
	wire  logic i2c_stop = scl & scl_prev_q & ~sda_prev_q & sda;
	wire  logic byte_end = scl_fall & ~ack_q & (cnt_q == 4'h8);
	wire  logic wr_fire = byte_end & (i2c_q == st_wdata);
	wire  logic rd_load = scl_fall & ack_q & (i2c_q == st_rdata);

	// i2c slave: shift on scl rise, drive sda after scl fall
	always_ff @(posedge i_clock) begin
		scl_prev_q <= scl;
		sda_prev_q <= sda;
		if (i_sys_rst) begin
			i2c_q <= st_idle;
			ack_q <= 1'b0;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			o_sda_oe <= 1'b0;
		end else if (i2c_start) begin
			i2c_q <= st_addr;
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
			o_sda_oe <= 1'b0;
		end else if (i2c_stop) begin
			i2c_q <= st_idle;
			ack_q <= 1'b0;
			o_sda_oe <= 1'b0;
		end else if (scl_rise) begin
			if (i2c_q == st_rack) begin
				if (sda)
					i2c_q <= st_idle; // master nack ends the read
				else begin
					i2c_q <= st_rdata;
					ack_q <= 1'b1;
					ptr_q <= ptr_q + 8'h01;
				end
			end else if (!ack_q && i2c_q != st_idle) begin
				sh_q <= {sh_q[6:0], sda};
				cnt_q <= cnt_q + 4'h1;
			end
		end else if (scl_fall) begin
			if (ack_q) begin
				ack_q <= 1'b0;
				cnt_q <= 4'h0;
				o_sda_oe <= 1'b0;
				if (i2c_q == st_rdata) begin
					tx_q <= rd_data;
					o_sda_oe <= ~rd_data[7];
				end
			end else if (cnt_q == 4'h8) begin
				cnt_q <= 4'h0;
				case (i2c_q)
					st_addr: begin
						if (sh_q[7:1] == lsm_pkg::I2C_DEV_ADDR) begin
							ack_q <= 1'b1;
							o_sda_oe <= 1'b1;
							i2c_q <= sh_q[0] ? st_rdata : st_reg;
						end else
							i2c_q <= st_idle;
					end
					st_reg: begin
						ptr_q <= sh_q;
						ack_q <= 1'b1;
						o_sda_oe <= 1'b1;
						i2c_q <= st_wdata;
					end
					st_wdata: begin
						ptr_q <= ptr_q + 8'h01;
						ack_q <= 1'b1;
						o_sda_oe <= 1'b1;
					end
					st_rdata: begin
						i2c_q <= st_rack;
						o_sda_oe <= 1'b0;
					end
					default: i2c_q <= st_idle;
				endcase
			end else if (i2c_q == st_rdata) begin
				tx_q <= {tx_q[6:0], 1'b1};
				o_sda_oe <= ~tx_q[6];
			end
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge i_clock)
		o_sda_out <= 1'b0;

	// configuration registers
	logic [7:0] sens_cfg_q;
	logic [7:0] gain_q;
	logic [7:0] vlim_q;
	logic [7:0] tlim_q;
	logic [7:0] alm_en_q;
	logic [7:0] alm_fwd_q;
	logic [7:0] clr_keep_q;
	logic       rate_fast_q;
	logic [2:0] boot_q;
	function automatic logic hit(input logic [7:0] a);
		return wr_fire && ptr_q == a;
	endfunction
	// clear bits are pulses, never stored
	wire logic bc_clr = hit(lsm_pkg::OFS_CLR)
		& sh_q[lsm_pkg::CLR_BC_BIT]; // [R23]
	wire logic built_in_self_test_clr = hit(lsm_pkg::OFS_CLR)
		& sh_q[lsm_pkg::CLR_BUILT_IN_SELF_TEST_BIT]; // [R23]

	// strap is taken once the synchroniser has settled after reset
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			boot_q <= 3'h0;
			sens_cfg_q <= 8'h00;
			gain_q <= lsm_pkg::RST_GAIN;
			vlim_q <= lsm_pkg::RST_VLIM;
			tlim_q <= lsm_pkg::RST_TLIM;
			alm_en_q <= 8'h00;
			alm_fwd_q <= 8'h00;
			clr_keep_q <= 8'h00;
			rate_fast_q <= 1'b0;
		end else begin
			if (boot_q != lsm_pkg::STRAP_WAIT_CYC)
				boot_q <= boot_q + 3'h1;
			if (boot_q == lsm_pkg::STRAP_WAIT_CYC - 3'h1)
				rate_fast_q <= strap; // [R7]
			if (wr_fire)
				case (ptr_q) // [R22]
					lsm_pkg::OFS_SENS_CFG: sens_cfg_q <= sh_q;
					lsm_pkg::OFS_GAIN:     gain_q <= sh_q;
					lsm_pkg::OFS_VLIM:     vlim_q <= sh_q;
					lsm_pkg::OFS_TLIM:     tlim_q <= sh_q;
					lsm_pkg::OFS_ALM_EN:   alm_en_q <= sh_q;
					lsm_pkg::OFS_ALM_FWD:  alm_fwd_q <= sh_q;
					lsm_pkg::OFS_BC_RATE:  rate_fast_q <= sh_q[0]; // [R7]
					lsm_pkg::OFS_CLR:
						clr_keep_q <= sh_q & lsm_pkg::CLR_KEEP_MASK;
					default: ;
				endcase
		end
	end

	// sensors: pin select and converters
	wire logic [10:0] sel_mv = sens_cfg_q[lsm_pkg::SENS_PIN_BIT] ?
		i_pin_mv[1] : i_pin_mv[0]; // [R18]
	wire logic volt_en = sens_cfg_q[lsm_pkg::SENS_VEN_BIT];
	wire logic temp_en = sens_cfg_q[lsm_pkg::SENS_TEN_BIT];
	logic [2:0] vcode_q;
	logic [2:0] tcode_q;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			vcode_q <= 3'h0;
			tcode_q <= 3'h0;
		end else begin
			vcode_q <= volt_en ? volt_code(sel_mv) : 3'h0; // [R16] [R19]
			tcode_q <= temp_en ? temp_code(i_temp_c) : 3'h0; // [R16] [R20]
		end
	end
	// limit compare, upper in [6:4], lower in [2:0]
	wire logic volt_lo = volt_en & (vcode_q < vlim_q[2:0]); // [R17]
	wire logic volt_hi = volt_en & (vcode_q > vlim_q[6:4]); // [R17]
	wire logic temp_lo = temp_en & (tcode_q < tlim_q[2:0]); // [R17]
	wire logic temp_hi = temp_en & (tcode_q > tlim_q[6:4]); // [R17]
	wire logic [3:0] sens_st = {volt_hi, volt_lo, temp_hi, temp_lo};
	wire logic alarm_any = |(sens_st & alm_en_q[3:0]);

	// back channel: biphase mark, edge at every cell, mid edge for a one
	logic       bcl_prev_q;
	logic [6:0] gap_q;
	logic       half_q;
	logic [4:0] nbits_q;
	logic [7:0] bcrc_q;
	logic [29:0] bsh_q;
	wire  logic edge_bc = bcl ^ bcl_prev_q;
	wire  logic [6:0] thr = rate_fast_q ?
		lsm_pkg::BC_FAST_SHORT : lsm_pkg::BC_SLOW_SHORT; // [R7]
	wire  logic [6:0] idle_lim = rate_fast_q ?
		lsm_pkg::BC_FAST_IDLE : lsm_pkg::BC_SLOW_IDLE;
	wire  logic idle = gap_q >= idle_lim;
	wire  logic short_gap = gap_q < thr;
	// a bit ends on a long cell or on the second short half [R6]
	wire  logic bit_done = edge_bc & ~idle & (~short_gap | half_q);
	wire  logic bit_val = short_gap;
	wire  logic [7:0] bcrc_next = crc8_bit(bcrc_q, bit_val);
	wire  logic frame_end = bit_done & (nbits_q == lsm_pkg::BC_LAST_BIT);
	wire  logic crc_ok = bcrc_next == 8'h00;
	wire  logic bad_frame = frame_end & ~crc_ok;
	wire  lsm_pkg::bc_frame_s fr = {bsh_q[28:0], bit_val}; // [R5]
	logic       rlock_q;
	logic       built_in_self_test_q;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			bcl_prev_q <= 1'b0;
			gap_q <= 7'h7F;
			half_q <= 1'b0;
			nbits_q <= 5'h00;
			bcrc_q <= 8'h00;
			bsh_q <= 30'h0;
		end else begin
			bcl_prev_q <= bcl;
			gap_q <= edge_bc ? 7'h00 :
				(gap_q == 7'h7F ? gap_q : gap_q + 7'h01);
			if (edge_bc && idle) begin
				nbits_q <= 5'h00; // quiet line marks a frame start
				bcrc_q <= 8'h00;
				half_q <= 1'b0;
			end else if (bit_done) begin
				bsh_q <= fr;
				bcrc_q <= frame_end ? 8'h00 : bcrc_next;
				nbits_q <= frame_end ? 5'h00 : nbits_q + 5'h01; // [R5]
				half_q <= 1'b0;
			end else if (edge_bc)
				half_q <= 1'b1;
		end
	end

	// good frames deliver content; bad ones feed the error counters
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rlock_q <= 1'b0;
			built_in_self_test_q <= 1'b0;
			o_bc_i2c <= 8'h00;
			o_bc_gpio <= 4'h0;
			o_bc_strobe <= 1'b0;
		end else begin
			o_bc_strobe <= frame_end & crc_ok;
			if (frame_end && crc_ok) begin
				rlock_q <= fr.rlock; // [R9]
				built_in_self_test_q <= fr.built_in_self_test;
				o_bc_i2c <= fr.i2c; // [R5]
				o_bc_gpio <= fr.gpio;
			end
		end
	end

	logic        bc_err_q;
	logic [15:0] bc_cnt_q;
	logic        built_in_self_test_err_q;
	logic [7:0]  built_in_self_test_cnt_q;
	wire  logic  built_in_self_test_bad = bad_frame & built_in_self_test_q;
	// set wins over clear: a clash leaves flag set and count at one
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			bc_err_q <= 1'b0;
			bc_cnt_q <= 16'h0000;
			built_in_self_test_err_q <= 1'b0;
			built_in_self_test_cnt_q <= 8'h00;
		end else begin
			bc_err_q <= bad_frame | (bc_err_q & ~bc_clr); // [R10]
			if (bad_frame)
				bc_cnt_q <= bc_clr ? 16'h0001 : (bc_cnt_q == 16'hFFFF ?
					bc_cnt_q : bc_cnt_q + 16'h0001); // [R11] [R23]
			else if (bc_clr)
				bc_cnt_q <= 16'h0000; // [R12]
			built_in_self_test_err_q <= built_in_self_test_bad | (built_in_self_test_err_q & ~built_in_self_test_clr); // [R13]
			if (built_in_self_test_bad)
				built_in_self_test_cnt_q <= built_in_self_test_clr ? 8'h01 : (built_in_self_test_cnt_q == 8'hFF ?
					built_in_self_test_cnt_q : built_in_self_test_cnt_q + 8'h01); // [R14] [R23]
			else if (built_in_self_test_clr)
				built_in_self_test_cnt_q <= 8'h00; // [R15]
		end
	end

	// camera receiver checks
	logic [15:0] ccrc_q;
	logic        in_pkt_q;
	logic        chk_err_q;
	logic [7:0]  csi_cnt_q;
	logic [7:0]  ln01_q;
	logic [7:0]  ln23_q;
	logic [7:0]  clkln_q;
	wire  logic [15:0] crc_base = i_pkt.sop ? lsm_pkg::CRC16_INIT : ccrc_q;
	wire  logic [15:0] pkt_crc = i_pkt.valid ?
		crc16_byte(crc_base, i_pkt.data) : crc_base;
	wire  logic mismatch = i_pkt.eop & (pkt_crc != i_pkt.chk); // [R1]
	wire  logic lane_evt = |i_lane_err;
	function automatic logic rd_hit(input logic [7:0] a);
		return rd_load && ptr_q == a;
	endfunction

	// status clears on read, but a new error in that cycle is kept
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			ccrc_q <= lsm_pkg::CRC16_INIT;
			in_pkt_q <= 1'b0;
			chk_err_q <= 1'b0;
			csi_cnt_q <= 8'h00;
			ln01_q <= 8'h00;
			ln23_q <= 8'h00;
			clkln_q <= 8'h00;
		end else begin
			if (i_pkt.valid || i_pkt.sop)
				ccrc_q <= pkt_crc; // [R1]
			in_pkt_q <= (i_pkt.sop | in_pkt_q) & ~i_pkt.eop;
			chk_err_q <= mismatch
				| (chk_err_q & ~rd_hit(lsm_pkg::OFS_CSI_ST)); // [R1]
			if (mismatch || lane_evt)
				csi_cnt_q <= csi_cnt_q == 8'hFF ?
					csi_cnt_q : csi_cnt_q + 8'h01; // [R3] [R23]
			else if (rd_hit(lsm_pkg::OFS_CSI_CNT))
				csi_cnt_q <= 8'h00;
			ln01_q <= i_lane_err.ln01
				| (ln01_q & ~{8{rd_hit(lsm_pkg::OFS_LN01)}}); // [R3]
			ln23_q <= i_lane_err.ln23
				| (ln23_q & ~{8{rd_hit(lsm_pkg::OFS_LN23)}}); // [R3]
			clkln_q <= i_lane_err.clk
				| (clkln_q & ~{8{rd_hit(lsm_pkg::OFS_CLKLN)}}); // [R3]
		end
	end

	// register read selection
	always_comb begin
		case (ptr_q)
			lsm_pkg::OFS_SENS_CFG: rd_data = sens_cfg_q;
			lsm_pkg::OFS_GAIN:     rd_data = gain_q;
			lsm_pkg::OFS_VLIM:     rd_data = vlim_q;
			lsm_pkg::OFS_TLIM:     rd_data = tlim_q;
			lsm_pkg::OFS_ALM_EN:   rd_data = alm_en_q;
			lsm_pkg::OFS_ALM_FWD:  rd_data = alm_fwd_q;
			lsm_pkg::OFS_CLR:      rd_data = clr_keep_q;
			lsm_pkg::OFS_LINK:     rd_data = {1'b0, rlock_q, 2'b00,
				built_in_self_test_err_q, pll_lock, bc_err_q, 1'b0}; // [R8] [R9] [R10] [R13]
			lsm_pkg::OFS_BUILT_IN_SELF_TEST_CNT: rd_data = built_in_self_test_cnt_q; // [R14]
			lsm_pkg::OFS_BC_CNT_A: rd_data = bc_cnt_q[7:0]; // [R11]
			lsm_pkg::OFS_BC_CNT_B: rd_data = bc_cnt_q[15:8]; // [R11]
			lsm_pkg::OFS_SENS_ST:  rd_data = {1'b0, vcode_q,
				sens_st}; // [R21]
			lsm_pkg::OFS_BC_RATE:  rd_data = {7'h00, rate_fast_q};
			lsm_pkg::OFS_CSI_CNT:  rd_data = csi_cnt_q;
			lsm_pkg::OFS_CSI_ST:   rd_data = {7'h00, chk_err_q};
			lsm_pkg::OFS_LN01:     rd_data = ln01_q;
			lsm_pkg::OFS_LN23:     rd_data = ln23_q;
			lsm_pkg::OFS_CLKLN:    rd_data = clkln_q;
			default:               rd_data = 8'h00;
		endcase
	end

	// forward frame: crc over content, then invert whole payload if heavy
	logic [2:0] div_q;
	wire  logic fwd_tick = div_q == lsm_pkg::FWD_PERIOD_CYC;
	wire  lsm_pkg::fwd_raw_s raw = '{video: i_video, i2c: i_fwd_i2c,
		pkt_active: in_pkt_q,
		chk_fwd: chk_err_q & alm_en_q[lsm_pkg::ALM_CHK_BIT]
			& alm_fwd_q[lsm_pkg::FWD_CHK_BIT], // [R2]
		alarm: alarm_any & alm_fwd_q[lsm_pkg::FWD_SENS_BIT], // [R17]
		rsvd: 3'h0};
	wire  logic [37:0] payload = {raw, crc8_word(raw)}; // [R4]
	wire  logic heavy = $countones(payload) > lsm_pkg::FWD_HALF_ONES;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			div_q <= 3'h0;
			o_fwd_frame <= 40'h0;
			o_fwd_strobe <= 1'b0;
		end else begin
			div_q <= fwd_tick ? 3'h0 : div_q + 3'h1;
			o_fwd_strobe <= fwd_tick;
			if (fwd_tick)
				o_fwd_frame <= heavy ? {lsm_pkg::FWD_HDR_INV, ~payload}
					: {lsm_pkg::FWD_HDR_PLAIN, payload}; // [R4]
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	sequence s_bad;
		bad_frame;
	endsequence
	sequence s_clr_only;
		bc_clr && !bad_frame;
	endsequence
	a_chk_flag: assert property (mismatch |=> chk_err_q) // [R1]
		else $error("checksum mismatch not recorded");
	a_fwd_balance: assert property (o_fwd_strobe |-> // [R4]
		$countones(o_fwd_frame) <= 20)
		else $error("forward frame unbalanced");
	a_bc_flag: assert property (s_bad |=> bc_err_q) // [R10]
		else $error("crc flag missing");
	a_bc_count: assert property (s_bad ##0 // [R11]
		(!bc_clr && bc_cnt_q != 16'hFFFF)
		|=> bc_cnt_q == $past(bc_cnt_q) + 16'h0001)
		else $error("crc count did not step");
	a_bc_clear: assert property (s_clr_only |=> // [R12]
		bc_cnt_q == 16'h0000 && !bc_err_q)
		else $error("crc counter not cleared");
	a_built_in_self_test_flag: assert property (bad_frame && built_in_self_test_q |=> // [R13]
		built_in_self_test_err_q && built_in_self_test_cnt_q != 8'h00)
		else $error("self-test error not flagged");
	a_built_in_self_test_clear: assert property (built_in_self_test_clr && !built_in_self_test_bad |=> // [R15]
		built_in_self_test_cnt_q == 8'h00)
		else $error("self-test counter not cleared");
	a_cnt_hold: assert property (!bad_frame && !bc_clr |=> // [R23]
		$stable(bc_cnt_q))
		else $error("crc counter moved without cause");
	a_volt_code: assert property (volt_en ##1 volt_en |-> // [R19]
		vcode_q == volt_code($past(sel_mv)))
		else $error("voltage code wrong");
	a_rlock: assert property (frame_end && crc_ok |=> // [R9]
		rlock_q == $past(fr.rlock) && o_bc_strobe)
		else $error("remote lock not taken");
endmodule

// File: hdl/lsm_pkg.sv
package lsm_pkg;
	// register offsets
	localparam logic [7:0] OFS_SENS_CFG = 8'h17;
	localparam logic [7:0] OFS_GAIN     = 8'h18;
	localparam logic [7:0] OFS_VLIM     = 8'h1A;
	localparam logic [7:0] OFS_TLIM     = 8'h1B;
	localparam logic [7:0] OFS_ALM_EN   = 8'h1D;
	localparam logic [7:0] OFS_ALM_FWD  = 8'h1E;
	localparam logic [7:0] OFS_CLR      = 8'h49;
	localparam logic [7:0] OFS_LINK     = 8'h52;
	localparam logic [7:0] OFS_BUILT_IN_SELF_TEST_CNT = 8'h54;
	localparam logic [7:0] OFS_BC_CNT_A = 8'h55;
	localparam logic [7:0] OFS_BC_CNT_B = 8'h56;
	localparam logic [7:0] OFS_SENS_ST  = 8'h57;
	localparam logic [7:0] OFS_BC_RATE  = 8'h58;
	localparam logic [7:0] OFS_CSI_CNT  = 8'h5C;
	localparam logic [7:0] OFS_CSI_ST   = 8'h5D;
	localparam logic [7:0] OFS_LN01     = 8'h5E;
	localparam logic [7:0] OFS_LN23     = 8'h5F;
	localparam logic [7:0] OFS_CLKLN    = 8'h60;
	// field positions
	localparam int CLR_BC_BIT   = 3;
	localparam int CLR_BUILT_IN_SELF_TEST_BIT = 5;
	localparam int SENS_PIN_BIT = 1;
	localparam int SENS_VEN_BIT = 2;
	localparam int SENS_TEN_BIT = 3;
	localparam int ALM_CHK_BIT  = 4;
	localparam int FWD_SENS_BIT = 0;
	localparam int FWD_CHK_BIT  = 1;
	localparam logic [7:0] CLR_KEEP_MASK = 8'hD7;
	// values after reset
	localparam logic [7:0] RST_GAIN = 8'hB2;
	localparam logic [7:0] RST_VLIM = 8'h62;
	localparam logic [7:0] RST_TLIM = 8'h61;
	localparam logic [6:0] I2C_DEV_ADDR = 7'h3A;
	// back channel timing, model runs slower than the real line
	localparam int CLK_PERIOD_NS = 20;
	localparam int BC_FAST_MBPS  = 50;
	localparam int BC_SLOW_MBPS  = 10;
	localparam int BC_TIME_SCALE = 8;
	localparam int BC_FAST_BIT_CYC =
		1000 * BC_TIME_SCALE / BC_FAST_MBPS / CLK_PERIOD_NS;
	localparam int BC_SLOW_BIT_CYC =
		1000 * BC_TIME_SCALE / BC_SLOW_MBPS / CLK_PERIOD_NS;
	localparam logic [6:0] BC_FAST_SHORT = 7'(BC_FAST_BIT_CYC * 3 / 4);
	localparam logic [6:0] BC_SLOW_SHORT = 7'(BC_SLOW_BIT_CYC * 3 / 4);
	localparam logic [6:0] BC_FAST_IDLE  = 7'(BC_FAST_BIT_CYC * 2);
	localparam logic [6:0] BC_SLOW_IDLE  = 7'(BC_SLOW_BIT_CYC * 2);
	localparam logic [4:0] BC_LAST_BIT   = 5'h1D;
	localparam logic [2:0] FWD_PERIOD_CYC = 3'h7;
	// the strap synchroniser needs four edges after reset to show the pin
	localparam logic [2:0] STRAP_WAIT_CYC = 3'h5;
	localparam logic [1:0] FWD_HDR_PLAIN = 2'h1;
	localparam logic [1:0] FWD_HDR_INV   = 2'h2;
	localparam int FWD_HALF_ONES = 19;
	localparam logic [15:0] CRC16_INIT = 16'hFFFF;
	localparam logic [15:0] CRC16_POLY = 16'h8408;
	localparam logic [7:0]  CRC8_POLY  = 8'h07;
	localparam int VOLT_MIN_MV  = 850;
	localparam int VOLT_MAX_MV  = 1150;
	localparam int VOLT_STEP_MV = 50;
	localparam int TEMP_BOUND [7] = '{-30, -10, 15, 35, 55, 75, 100};
	typedef struct packed {
		logic sop; logic valid; logic eop;
		logic [7:0] data; logic [15:0] chk;
	} csi_pkt_s;
	typedef struct packed {
		logic [7:0] ln01; logic [7:0] ln23; logic [7:0] clk;
	} lane_err_s;
	typedef struct packed {
		logic [7:0] i2c; logic [3:0] gpio; logic rlock; logic built_in_self_test;
		logic [7:0] spare; logic [7:0] crc;
	} bc_frame_s;
	typedef struct packed {
		logic [15:0] video; logic [7:0] i2c; logic pkt_active;
		logic chk_fwd; logic alarm; logic [2:0] rsvd;
	} fwd_raw_s;
endpackage

// File: test/far_end_model.sv
`timescale 1ns/1ps
// remote end of the back channel; the line keeps its level between frames
module far_end_model (
	input  wire logic i_clock,
	output logic      o_line
);
	initial o_line = 1'b0;
	// 22 content bits plus crc8; bad spoils the crc on purpose
	// h is half a cell in clocks, chosen by the rate under
	task automatic send(input logic [21:0] p, input logic bad,
		input int h);
		logic [7:0]  c;
		logic [29:0] f;
		c = 8'h00;
		for (int i = 21; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? 8'h07 : 8'h00);
		end
		f = {p, c ^ {7'h00, bad}}; // 30 bits, msb first
		repeat (4 * h) @(posedge i_clock);
		for (int i = 29; i >= 0; i--) begin
			o_line <= ~o_line; // edge at each cell start, mid edge for 1
			repeat (h) @(posedge i_clock);
			if (f[i]) o_line <= ~o_line;
			repeat (h) @(posedge i_clock);
		end
		o_line <= ~o_line; // edge that closes the last bit
	endtask
endmodule

// File: test/link_status_monitor_tb.sv
`timescale 1ns/1ps
module link_status_monitor_tb;
	logic              i_clock, i_sys_rst, scl, sda_m, bc_line, pll;
	logic              o_sda_out, o_sda_oe, o_fwd_strobe, o_bc_strobe;
	logic [39:0]       o_fwd_frame;
	logic [7:0]        o_bc_i2c, d;
	logic [3:0]        o_bc_gpio;
	lsm_pkg::csi_pkt_s pkt;
	logic [1:0][10:0]  pin_mv;
	int                fails = 0;
	int                comparisons = 0;
	int                half = lsm_pkg::BC_FAST_BIT_CYC / 2;
	logic [7:0]        temp;
	wire               sda = sda_m & ~o_sda_oe; // pull-up on the wire
	link_status_monitor uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_scl(scl), .i_sda(sda), .o_sda_out(o_sda_out),
		.o_sda_oe(o_sda_oe), .i_bc_line(bc_line), .i_mode_strap(1'b1),
		.i_fast_pll_locked(pll), .i_pkt(pkt), .i_lane_err('0),
		.i_video(16'h1234), .i_fwd_i2c(8'h5A), .i_pin_mv(pin_mv),
		.i_temp_c(temp), .o_fwd_frame(o_fwd_frame),
		.o_fwd_strobe(o_fwd_strobe), .o_bc_i2c(o_bc_i2c),
		.o_bc_gpio(o_bc_gpio), .o_bc_strobe(o_bc_strobe));
	far_end_model far (.i_clock(i_clock), .o_line(bc_line));
	task automatic report_and_stop();
		if (fails == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	// sda moves mid low phase, so the synced copies never race scl
	task automatic bit_io(input logic b, output logic r);
		tick(4);
		sda_m <= b;
		tick(6);
		scl <= 1'b1;
		tick(8);
		r = sda;
		scl <= 1'b0;
	endtask
	task automatic start();
		tick(4);
		sda_m <= 1'b1;
		tick(6);
		scl <= 1'b1;
		tick(8);
		sda_m <= 1'b0;
		tick(8);
		scl <= 1'b0;
	endtask
	task automatic stop();
		tick(4);
		sda_m <= 1'b0;
		tick(6);
		scl <= 1'b1;
		tick(8);
		sda_m <= 1'b1;
		tick(8);
	endtask
	task automatic tx(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(v[i], a);
		bit_io(1'b1, a);
		chk("ack", 8'h00, {7'h00, a});
		chk("sda out", 8'h00, {7'h00, o_sda_out});
	endtask
	// next forward frame, undone if sent inverted
	task automatic fwd(input logic al);
		logic [37:0] p;
		while (o_fwd_strobe !== 1'b1) @(posedge i_clock);
		p = o_fwd_frame[39:38] == lsm_pkg::FWD_HDR_INV ?
			~o_fwd_frame[37:0] : o_fwd_frame[37:0];
		chk("fwd video", 8'h12, p[37:30]);
		chk("fwd i2c", 8'h5A, p[21:14]);
		chk("fwd alarm", {7'h00, al}, {7'h00, p[11]});
	endtask
	task automatic wr(input logic [7:0] o, v);
		start();
		tx({lsm_pkg::I2C_DEV_ADDR, 1'b0});
		tx(o);
		tx(v);
		stop();
	endtask
	// register read, masked compare
	task automatic rc(input string n, input logic [7:0] o, m, e);
		logic a;
		start();
		tx({lsm_pkg::I2C_DEV_ADDR, 1'b0});
		tx(o);
		start();
		tx({lsm_pkg::I2C_DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(1'b1, a);
		stop();
		chk(n, e, d & m);
	endtask
	task automatic bc(input logic [21:0] p, input logic bad);
		logic s;
		s = 1'b0;
		far.send(p, bad, half);
		repeat (20) begin
			@(posedge i_clock);
			if (o_bc_strobe === 1'b1) s = 1'b1;
		end
		chk("bc strobe", {7'h00, ~bad}, {7'h00, s});
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] b);
		logic [15:0] c;
		c = lsm_pkg::CRC16_INIT;
		for (int i = 0; i < 8; i++) begin
			c = (c >> 1) ^ ((c[0] ^ b[i]) ? lsm_pkg::CRC16_POLY : 16'h0000);
		end
		return c;
	endfunction
	task automatic pkt_one(input logic [7:0] b, input logic [15:0] c);
		@(posedge i_clock);
		pkt <= {3'b111, b, c};
		@(posedge i_clock);
		pkt <= '0;
	endtask
	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	// whole run needs about 24k cycles
	initial begin
		#1000000;
		fails++;
		report_and_stop();
	end
	initial begin
		i_sys_rst = 1'b1;
		scl = 1'b1;
		sda_m = 1'b1;
		pll = 1'b0;
		pkt = '0;
		pin_mv = {11'h3FC, 11'h320};
		temp = 8'h19;
		tick(12);
		i_sys_rst <= 1'b0;
		tick(8);
		rc("gain", lsm_pkg::OFS_GAIN, 8'hFF, lsm_pkg::RST_GAIN);
		rc("vlim", lsm_pkg::OFS_VLIM, 8'hFF, lsm_pkg::RST_VLIM);
		rc("bc rate", lsm_pkg::OFS_BC_RATE, 8'hFF, 8'h01);
		wr(8'h30, 8'hAA);
		rc("unmapped", 8'h30, 8'hFF, 8'h00);
		pll <= 1'b1;
		chk("fwd hdr", 8'h01, {7'h00, ^o_fwd_frame[39:38]});
		fwd(1'b0);
		bc({8'hC5, 4'hA, 2'b10, 8'h00}, 1'b0);
		chk("bc i2c", 8'hC5, o_bc_i2c);
		chk("bc gpio", 8'h0A, {4'h0, o_bc_gpio});
		rc("lock", lsm_pkg::OFS_LINK, 8'h44, 8'h44);
		bc({8'hC5, 4'hA, 2'b10, 8'h00}, 1'b1);
		rc("crc flag", lsm_pkg::OFS_LINK, 8'h02, 8'h02);
		rc("crc cnt a", lsm_pkg::OFS_BC_CNT_A, 8'hFF, 8'h01);
		rc("crc cnt b", lsm_pkg::OFS_BC_CNT_B, 8'hFF, 8'h00);
		wr(lsm_pkg::OFS_CLR, 8'h08);
		rc("crc cnt a", lsm_pkg::OFS_BC_CNT_A, 8'hFF, 8'h00);
		rc("crc flag", lsm_pkg::OFS_LINK, 8'h02, 8'h00);
		rc("clear reg", lsm_pkg::OFS_CLR, 8'hFF, 8'h00);
		bc({8'h3C, 4'h5, 2'b01, 8'h00}, 1'b0);
		bc({8'h3C, 4'h5, 2'b01, 8'h00}, 1'b1);
		rc("st flag", lsm_pkg::OFS_LINK, 8'h08, 8'h08);
		rc("st cnt", lsm_pkg::OFS_BUILT_IN_SELF_TEST_CNT, 8'hFF, 8'h01);
		wr(lsm_pkg::OFS_CLR, 8'h20);
		rc("st cnt", lsm_pkg::OFS_BUILT_IN_SELF_TEST_CNT, 8'hFF, 8'h00);
		pkt_one(8'h5A, crc16(8'h5A));
		rc("csi st", lsm_pkg::OFS_CSI_ST, 8'h01, 8'h00);
		pkt_one(8'h5A, crc16(8'h5A) ^ 16'h0001);
		rc("csi cnt", lsm_pkg::OFS_CSI_CNT, 8'hFF, 8'h01);
		rc("csi st", lsm_pkg::OFS_CSI_ST, 8'h01, 8'h01);
		rc("csi st", lsm_pkg::OFS_CSI_ST, 8'h01, 8'h00);
		wr(lsm_pkg::OFS_SENS_CFG, 8'h06);
		wr(lsm_pkg::OFS_ALM_EN, 8'h0F);
		rc("sense", lsm_pkg::OFS_SENS_ST, 8'hFF, 8'h40);
		pin_mv[1] <= 11'h4B0;
		rc("sense", lsm_pkg::OFS_SENS_ST, 8'hFF, 8'h78);
		pin_mv[1] <= 11'h320;
		rc("sense", lsm_pkg::OFS_SENS_ST, 8'hFF, 8'h04);
		temp <= 8'h28;
		wr(lsm_pkg::OFS_SENS_CFG, 8'h0E);
		wr(lsm_pkg::OFS_TLIM, 8'h33);
		rc("temp", lsm_pkg::OFS_SENS_ST, 8'h03, 8'h02);
		temp <= 8'hD8;
		rc("temp", lsm_pkg::OFS_SENS_ST, 8'h03, 8'h01);
		wr(lsm_pkg::OFS_ALM_FWD, 8'h01);
		fwd(1'b1);
		wr(lsm_pkg::OFS_BC_RATE, 8'h00);
		half = lsm_pkg::BC_SLOW_BIT_CYC / 2;
		bc({8'h96, 4'h3, 2'b00, 8'h00}, 1'b0);
		chk("bc slow", 8'h96, o_bc_i2c);
		report_and_stop();
	end
endmodule
